// >>> spa_ptr_adjust.v
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
`include "spa_map.vh"
module spa_ptr_adjust (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output wire [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   input  wire        byte_en,
   input  wire        frame_sync,
   input  wire [7:0]  data_in,
   output reg         payload_take_r,
   output reg         tx_valid_r,
   output reg         tx_frame_r,
   output reg  [7:0]  tx_data_r
);
   // -------------------------------------------------------------------
   // event codes
   // -------------------------------------------------------------------
   localparam EV_NONE  = 3'h0;
   localparam EV_FORCE = 3'h1;
   localparam EV_SNDF  = 3'h2;
   localparam EV_NEG   = 3'h3;
   localparam EV_POS   = 3'h4;

   // -------------------------------------------------------------------
   // pointer step with wrap over the valid range
   // -------------------------------------------------------------------
   function [9:0] ptr_step;
      input [9:0] p;
      input       up;
      begin
         if (up)
            ptr_step = (p >= `SPA_PTR_MAX) ? 10'h000 : p + 10'h001;
         else
            ptr_step = (p == 10'h000) ? `SPA_PTR_MAX : p - 10'h001;
      end
   endfunction

   wire       rd_stb;
   wire [1:0] rd_idx;
   wire       wr_stb;
   wire [1:0] wr_idx;
   wire [7:0] wr_data;
   reg  [7:0] rd_data;
   wire [3:0] row_r;
   wire [6:0] col_r;

   reg        chk_r;
   reg        cndf_r;
   reg        force_bit_r;
   reg        sndf_bit_r;
   reg        force_pend_r;
   reg        sndf_pend_r;
   reg        pos_pend_r;
   reg        neg_pend_r;
   reg  [7:0] arb_high_r;
   reg  [7:0] arb_low_r;
   reg  [9:0] ptr_r;
   reg  [1:0] ss_r;
   reg  [2:0] evt_r;
   reg  [1:0] quiet_r;
   reg  [9:0] tx_ptr_r;
   wire [9:0] dec_ptr;
   wire [9:0] inc_ptr;

   reg  [2:0] evt_nxt;
   reg  [7:0] byte_nxt;
   reg        take_nxt;

   wire [3:0] cur_row;
   wire [6:0] cur_col;
   wire       ptr_row;
   wire       h1_slot;
   wire       pstuff_slot;
   wire       ctrl_wr;
   wire       allow;
   wire       take_evt;
   wire [9:0] arb_ptr;

   // -------------------------------------------------------------------
   // bus slave and frame position
   // -------------------------------------------------------------------
   spa_ahb_slave u_bus (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hready    (hready),
      .hwdata    (hwdata),
      .rd_data   (rd_data),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .rd_stb    (rd_stb),
      .rd_idx    (rd_idx),
      .wr_stb    (wr_stb),
      .wr_idx_r  (wr_idx),
      .wr_data   (wr_data)
   );

   spa_frame_pos u_pos (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .byte_en    (byte_en),
      .frame_sync (frame_sync),
      .row_r      (row_r),
      .col_r      (col_r)
   );

   assign cur_row     = frame_sync ? 4'h0 : row_r;
   assign cur_col     = frame_sync ? 7'h00 : col_r;
   assign ptr_row     = (cur_row == `SPA_PTR_ROW);
   assign h1_slot     = byte_en & ptr_row & (cur_col == `SPA_COL_H1);
   assign pstuff_slot = byte_en & ptr_row & (cur_col == `SPA_COL_PSTUFF);
   assign ctrl_wr     = wr_stb & (wr_idx == `SPA_IDX_CTRL);
   assign arb_ptr     = {arb_high_r[1:0], arb_low_r};
   assign dec_ptr     = ptr_r ^ `SPA_D_MASK;
   assign inc_ptr     = ptr_r ^ `SPA_I_MASK;
   assign allow       = ~chk_r | (quiet_r == `SPA_QUIET_FRAMES);
   assign take_evt    = h1_slot & allow & (evt_nxt != EV_NONE);

   // -------------------------------------------------------------------
   // register read mux
   // -------------------------------------------------------------------
   always @* begin
      rd_data = 8'h00;
      case (rd_idx)
         `SPA_IDX_CTRL:
            rd_data = {2'b00, force_bit_r, chk_r, neg_pend_r, pos_pend_r,
                       cndf_r, sndf_bit_r};
         `SPA_IDX_ARB_HIGH: rd_data = arb_high_r;
         `SPA_IDX_ARB_LOW:  rd_data = arb_low_r;
         `SPA_IDX_PTR:      rd_data = ptr_r[7:0];
         default:           rd_data = 8'h00;
      endcase
   end

   // -------------------------------------------------------------------
   // pick one pending command per frame
   // -------------------------------------------------------------------
   always @* begin
      evt_nxt = EV_NONE;
      if (force_pend_r)
         evt_nxt = EV_FORCE;
      else if (sndf_pend_r)
         evt_nxt = EV_SNDF;
      else if (neg_pend_r)
         evt_nxt = EV_NEG;
      else if (pos_pend_r)
         evt_nxt = EV_POS;
   end

   // -------------------------------------------------------------------
   // control register and command capture
   // -------------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chk_r        <= 1'b0;
         cndf_r       <= 1'b0;
         force_bit_r  <= 1'b0;
         sndf_bit_r   <= 1'b0;
         force_pend_r <= 1'b0;
         sndf_pend_r  <= 1'b0;
         pos_pend_r   <= 1'b0;
         neg_pend_r   <= 1'b0;
         arb_high_r   <= `SPA_ARB_RST;
         arb_low_r    <= `SPA_ARB_RST;
      end else begin
         if (take_evt & (evt_nxt == EV_FORCE))
            force_pend_r <= 1'b0;
         if (take_evt & (evt_nxt == EV_SNDF))
            sndf_pend_r <= 1'b0;
         if (take_evt & (evt_nxt == EV_NEG))
            neg_pend_r <= 1'b0;
         if (take_evt & (evt_nxt == EV_POS))
            pos_pend_r <= 1'b0;
         if (ctrl_wr) begin
            chk_r       <= wr_data[`SPA_B_CHK];
            cndf_r      <= wr_data[`SPA_B_CNDF];
            force_bit_r <= wr_data[`SPA_B_FORCE];
            sndf_bit_r  <= wr_data[`SPA_B_SNDF];
            if (wr_data[`SPA_B_FORCE] & ~force_bit_r)
               force_pend_r <= 1'b1;
            if (wr_data[`SPA_B_SNDF] & ~sndf_bit_r)
               sndf_pend_r <= 1'b1;
            if (wr_data[`SPA_B_POS])
               pos_pend_r <= 1'b1;
            if (wr_data[`SPA_B_NEG])
               neg_pend_r <= 1'b1;
         end
         if (wr_stb & (wr_idx == `SPA_IDX_ARB_HIGH))
            arb_high_r <= wr_data;
         if (wr_stb & (wr_idx == `SPA_IDX_ARB_LOW))
            arb_low_r <= wr_data;
      end
   end

   // -------------------------------------------------------------------
   // pointer state and per-frame event
   // -------------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ptr_r    <= `SPA_PTR_RST;
         ss_r     <= `SPA_SS_RST;
         evt_r    <= EV_NONE;
         quiet_r  <= 2'h0;
         tx_ptr_r <= `SPA_PTR_RST;
      end else begin
         if (byte_en & frame_sync & (quiet_r != `SPA_QUIET_FRAMES))
            quiet_r <= quiet_r + 2'h1;
         if (h1_slot) begin
            evt_r    <= take_evt ? evt_nxt : EV_NONE;
            tx_ptr_r <= ptr_r;
            if (take_evt) begin
               quiet_r <= 2'h0;
               case (evt_nxt)
                  EV_FORCE: begin
                     ss_r     <= arb_high_r[3:2];
                     tx_ptr_r <= arb_ptr;
                     ptr_r    <= arb_ptr;
                  end
                  EV_SNDF: begin
                     tx_ptr_r <= arb_ptr;
                     ptr_r    <= arb_ptr;
                  end
                  EV_NEG:   tx_ptr_r <= dec_ptr;
                  EV_POS:   tx_ptr_r <= inc_ptr;
                  default:  tx_ptr_r <= ptr_r;
               endcase
            end
         end
         if (pstuff_slot & (evt_r == EV_POS))
            ptr_r <= ptr_step(ptr_r, 1'b1);
         if (pstuff_slot & (evt_r == EV_NEG))
            ptr_r <= ptr_step(ptr_r, 1'b0);
      end
   end

   // -------------------------------------------------------------------
   // outbound byte selection
   // -------------------------------------------------------------------
   always @* begin
      byte_nxt = data_in;
      if (ptr_row & (cur_col == `SPA_COL_H1)) begin
         byte_nxt = {`SPA_NDF_NORM, ss_r, ptr_r[9:8]};
         if (take_evt & (evt_nxt == EV_FORCE))
            byte_nxt = arb_high_r;
         if (take_evt & (evt_nxt == EV_SNDF))
            byte_nxt = {`SPA_NDF_SET, ss_r, arb_ptr[9:8]};
         if (take_evt & (evt_nxt == EV_NEG))
            byte_nxt = {`SPA_NDF_NORM, ss_r, dec_ptr[9:8]};
         if (take_evt & (evt_nxt == EV_POS))
            byte_nxt = {`SPA_NDF_NORM, ss_r, inc_ptr[9:8]};
      end
      if (ptr_row & (cur_col == `SPA_COL_H2))
         byte_nxt = tx_ptr_r[7:0];
      if (ptr_row & (cur_col == `SPA_COL_H3))
         byte_nxt = (evt_r == EV_NEG) ? data_in : 8'h00;
      if (ptr_row & (cur_col == `SPA_COL_PSTUFF) & (evt_r == EV_POS))
         byte_nxt = 8'h00;
   end

   // upcoming slot consumes a payload byte
   always @* begin
      take_nxt = (col_r >= `SPA_TOH_COLS);
      if ((row_r == `SPA_PTR_ROW) & (col_r == `SPA_COL_H3) &
          (evt_r == EV_NEG))
         take_nxt = 1'b1;
      if ((row_r == `SPA_PTR_ROW) & (col_r == `SPA_COL_PSTUFF) &
          (evt_r == EV_POS))
         take_nxt = 1'b0;
   end

   // -------------------------------------------------------------------
   // output registers
   // -------------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         payload_take_r <= 1'b0;
         tx_valid_r     <= 1'b0;
         tx_frame_r     <= 1'b0;
         tx_data_r      <= 8'h00;
      end else begin
         payload_take_r <= take_nxt;
         tx_valid_r     <= byte_en;
         if (byte_en) begin
            tx_frame_r <= frame_sync;
            tx_data_r  <= byte_nxt;
         end
      end
   end
endmodule // spa_ptr_adjust

// >>> spa_map.vh
`ifndef SPA_MAP_VH
`define SPA_MAP_VH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SPA_OFS_CTRL      4'h0
`define SPA_OFS_ARB_HIGH  4'h4
`define SPA_OFS_ARB_LOW   4'h8
`define SPA_OFS_PTR_HIGH  4'hC
// ----------------------------------------------------------------------
// register index (byte offset / 4)
// ----------------------------------------------------------------------
`define SPA_IDX_CTRL      2'h0
`define SPA_IDX_ARB_HIGH  2'h1
`define SPA_IDX_ARB_LOW   2'h2
`define SPA_IDX_PTR       2'h3
// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define SPA_B_SNDF        0
`define SPA_B_CNDF        1
`define SPA_B_POS         2
`define SPA_B_NEG         3
`define SPA_B_CHK         4
`define SPA_B_FORCE       5
`define SPA_CTRL_RST      8'h00
`define SPA_ARB_RST       8'h00
// ----------------------------------------------------------------------
// pointer constants
// ----------------------------------------------------------------------
`define SPA_NDF_NORM      4'h6
`define SPA_NDF_SET       4'h9
`define SPA_SS_RST        2'h0
`define SPA_PTR_RST       10'h000
`define SPA_PTR_MAX       10'h30E
`define SPA_I_MASK        10'h2AA
`define SPA_D_MASK        10'h155
`define SPA_QUIET_FRAMES  2'h3
// ----------------------------------------------------------------------
// frame geometry
// ----------------------------------------------------------------------
`define SPA_LAST_ROW      4'h8
`define SPA_LAST_COL      7'h59
`define SPA_PTR_ROW       4'h3
`define SPA_COL_H1        7'h00
`define SPA_COL_H2        7'h01
`define SPA_COL_H3        7'h02
`define SPA_COL_PSTUFF    7'h03
`define SPA_TOH_COLS      7'h03
`endif

// >>> spa_frame_pos.v
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// row and column of the byte expected at the next strobe
// ----------------------------------------------------------------------
`include "spa_map.vh"
module spa_frame_pos (
   input  wire       hclk,
   input  wire       hresetn,
   input  wire       byte_en,
   input  wire       frame_sync,
   output reg  [3:0] row_r,
   output reg  [6:0] col_r
);
   wire [3:0] cur_row;
   wire [6:0] cur_col;
   assign cur_row = frame_sync ? 4'h0 : row_r;
   assign cur_col = frame_sync ? 7'h00 : col_r;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         row_r <= 4'h0;
         col_r <= 7'h00;
      end else if (byte_en) begin
         if (cur_col == `SPA_LAST_COL) begin
            col_r <= 7'h00;
            row_r <= (cur_row == `SPA_LAST_ROW) ? 4'h0 : cur_row + 4'h1;
         end else begin
            col_r <= cur_col + 7'h01;
            row_r <= cur_row;
         end
      end
   end
endmodule // spa_frame_pos

// >>> spa_ahb_slave.v
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// zero-wait ahb-lite slave, one word per register
// ----------------------------------------------------------------------
`include "spa_map.vh"
module spa_ahb_slave (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   input  wire [7:0]  rd_data,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   output wire        rd_stb,
   output wire [1:0]  rd_idx,
   output wire        wr_stb,
   output reg  [1:0]  wr_idx_r,
   output wire [7:0]  wr_data
);
   reg        wr_pend_r;
   wire       act;
   wire       hit;
   assign act     = hsel & hready & htrans[1];
   assign hit     = (haddr[31:4] == 28'h000_0000) & (haddr[1:0] == 2'h0);
   assign rd_stb  = act & ~hwrite & hit;
   assign rd_idx  = haddr[3:2];
   assign wr_stb  = wr_pend_r;
   assign wr_data = hwdata[7:0];
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_idx_r  <= 2'h0;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend_r <= act & hwrite & hit;
         if (act)
            wr_idx_r <= haddr[3:2];
         if (act & ~hwrite)
            hrdata <= hit ? {24'h00_0000, rd_data} : 32'h0000_0000;
      end
   end
endmodule // spa_ahb_slave

// >>> spa_frame_peer.sv
`timescale 1ns/1ns
// ------------------------------------
// upstream byte source and downstream
// frame receiver
// ------------------------------------
module spa_frame_peer (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        tx_valid_r,
   input  wire        tx_frame_r,
   input  wire [7:0]  tx_data_r,
   output logic       byte_en,
   output logic       frame_sync,
   output logic [7:0] data_in,
   output logic [7:0] h1,
   output logic [7:0] h2,
   output logic [7:0] h3,
   output logic [7:0] stf,
   output logic [7:0] h3_in,
   output int         hcnt
);
   logic       ph;
   logic [9:0] scnt;
   logic [9:0] rcnt;
   wire  [9:0] rpos = tx_frame_r ? 10'h000 : rcnt;
   initial {byte_en, frame_sync, data_in} = 10'h000;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph         <= 1'b0;
         scnt       <= 10'h000;
         rcnt       <= 10'h000;
         byte_en    <= 1'b0;
         frame_sync <= 1'b0;
         hcnt       <= 0;
      end else begin
         ph         <= ~ph;
         byte_en    <= ph;
         frame_sync <= ph && scnt == 10'h000;
         data_in    <= ph ? (8'h80 | scnt[7:0]) : ~data_in;
         if (ph)
            scnt <= scnt == 10'd809 ? 10'h000 : scnt + 10'h001;
         if (byte_en && scnt == 10'd273)
            h3_in <= data_in;
         if (tx_valid_r) begin
            rcnt <= rpos + 10'h001;
            case (rpos)
               10'd270: h1 <= tx_data_r;
               10'd271: h2 <= tx_data_r;
               10'd272: h3 <= tx_data_r;
               10'd273: begin
                  stf  <= tx_data_r;
                  hcnt <= hcnt + 1;
               end
               default: ;
            endcase
         end
      end
   end
endmodule  // spa_frame_peer

// >>> spa_ptr_adjust_monitor.sv
`timescale 1ns/1ns
`include "spa_map.vh"
// ------------------------------------
// stream checks at the block ports
// ------------------------------------
module spa_ptr_adjust_monitor (
   input wire       hclk,
   input wire       hresetn,
   input wire       hreadyout,
   input wire       hresp,
   input wire       byte_en,
   input wire       frame_sync,
   input wire       payload_take_r,
   input wire       tx_valid_r,
   input wire       tx_frame_r,
   input wire [7:0] tx_data_r
);
   logic [9:0] spos, tpos, ptr_q;
   logic [7:0] h1_q;
   logic       inc_q, dec_q;
   wire  [9:0] cpos = frame_sync ? 10'h000 : spos;
   wire  [9:0] pn   = {h1_q[1:0], tx_data_r};
   wire        slot = tx_valid_r && tpos == 10'd271;
   wire        norm = h1_q[7:4] == `SPA_NDF_NORM;
   wire        inc_now = norm && pn == (ptr_q ^ `SPA_I_MASK);
   wire        dec_now = norm && pn == (ptr_q ^ `SPA_D_MASK);
   wire        plain = norm && !inc_now && !dec_now;
   wire  [9:0] up = ptr_q == `SPA_PTR_MAX ? 10'h000 : ptr_q + 10'h001;
   wire  [9:0] dn = ptr_q == 10'h000 ? `SPA_PTR_MAX : ptr_q - 10'h001;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {spos, tpos, ptr_q} <= 30'h0000_0000;
         {h1_q, inc_q, dec_q} <= 10'h000;
      end else begin
         if (byte_en) begin
            spos <= cpos + 10'h001;
            tpos <= cpos;
         end
         if (tx_valid_r && tpos == 10'd270)
            h1_q <= tx_data_r;
         if (slot) begin
            inc_q <= inc_now;
            dec_q <= dec_now;
            if (!inc_now && !dec_now)
               ptr_q <= pn;
         end
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_tx_follows: assert property (tx_valid_r == $past(byte_en)
      && (!tx_valid_r || tx_frame_r == $past(frame_sync)))
      else $error("outbound byte not one cycle after strobe");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready okay");
   a_stuff_zero: assert property (
      tx_valid_r && tpos == 10'd273 && inc_q |-> tx_data_r == 8'h00)
      else $error("stuff byte not zero");
   a_stuff_slot: assert property (
      byte_en && cpos == 10'd273 |-> payload_take_r == !inc_q)
      else $error("payload take wrong at stuff slot");
   a_neg_take: assert property (
      byte_en && cpos == 10'd272 |-> payload_take_r == dec_q)
      else $error("h3 payload take wrong");
   a_h3_value: assert property (
      tx_valid_r && tpos == 10'd272 && !dec_q |-> tx_data_r == 8'h00)
      else $error("h3 not zero without decrement");
   a_inc_next: assert property (
      slot && inc_q && plain |-> pn == up)
      else $error("pointer not incremented");
   a_dec_next: assert property (
      slot && dec_q && plain |-> pn == dn)
      else $error("pointer not decremented");
   c_pos: cover property (tx_valid_r && tpos == 10'd273 && inc_q);
   c_neg: cover property (slot && dec_now);
   c_ndf: cover property (tx_valid_r && tpos == 10'd270
      && tx_data_r[7:4] == `SPA_NDF_SET);
endmodule  // spa_ptr_adjust_monitor

bind spa_ptr_adjust spa_ptr_adjust_monitor mon_u (.hclk, .hresetn,
   .hreadyout, .hresp, .byte_en, .frame_sync, .payload_take_r,
   .tx_valid_r, .tx_frame_r, .tx_data_r);

// >>> spa_ptr_adjust_test.sv
`timescale 1ns/1ns
`include "spa_map.vh"
// ------------------------------------
// pointer adjuster bench
// ------------------------------------
module spa_ptr_adjust_test;
   localparam logic [31:0] a_ctl = {28'h000_0000, `SPA_OFS_CTRL};
   localparam logic [31:0] a_hi  = {28'h000_0000, `SPA_OFS_ARB_HIGH};
   localparam logic [31:0] a_lo  = {28'h000_0000, `SPA_OFS_ARB_LOW};
   localparam logic [31:0] a_ptr = {28'h000_0000, `SPA_OFS_PTR_HIGH};
   logic        hclk;
   logic        hresetn = 1'b0;
   logic        hsel    = 1'b0;
   logic [31:0] haddr   = 32'h0000_0000;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [2:0]  hsize   = 3'h2;
   logic [31:0] hwdata  = 32'h0000_0000;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, byte_en, frame_sync;
   logic        payload_take_r, tx_valid_r, tx_frame_r;
   logic [7:0]  data_in, tx_data_r, h1, h2, h3, stf, h3_in;
   int          hcnt;
   int          err_count = 0;
   int          checked   = 0;
   // arb high, arb low, control, event h1/h2, next h1/h2
   logic [7:0]  rows [7][7] = '{
      '{8'hAB, 8'h05, 8'h20, 8'hAB, 8'h05, 8'h6B, 8'h05},
      '{8'hAB, 8'h05, 8'h04, 8'h69, 8'hAF, 8'h6B, 8'h06},
      '{8'hAB, 8'h05, 8'h08, 8'h6A, 8'h53, 8'h6B, 8'h05},
      '{8'h01, 8'h23, 8'h01, 8'h99, 8'h23, 8'h69, 8'h23},
      '{8'h63, 8'h0E, 8'h20, 8'h63, 8'h0E, 8'h63, 8'h0E},
      '{8'h63, 8'h0E, 8'h04, 8'h61, 8'hA4, 8'h60, 8'h00},
      '{8'h63, 8'h0E, 8'h08, 8'h61, 8'h55, 8'h63, 8'h0E}};
   spa_ptr_adjust dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata,
      .hreadyout, .hresp, .byte_en, .frame_sync, .data_in,
      .payload_take_r, .tx_valid_r, .tx_frame_r, .tx_data_r);
   spa_frame_peer peer_u (.hclk, .hresetn, .tx_valid_r, .tx_frame_r,
      .tx_data_r, .byte_en, .frame_sync, .data_in, .h1, .h2, .h3,
      .stf, .h3_in, .hcnt);
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   task automatic conclude;
      $display("err_count %0d checked %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         err_count++;
         conclude();
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a,
                      input logic [7:0] d, output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      rdy();
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      rdy();
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] e);
      logic [31:0] r;
      ahb(1'b0, a, 8'h00, r);
      chk(r[7:0], e);
      chk(r[31:24] | r[23:16] | r[15:8], 8'h00);
   endtask
   task automatic cmd(input logic [7:0] hi, lo, ctl);
      wr(a_hi, hi);
      wr(a_lo, lo);
      wr(a_ctl, ctl);
   endtask
   task automatic nxt;
      int h;
      int n;
      h = hcnt;
      n = 0;
      while (hcnt == h && n < 4000) begin
         @(posedge hclk);
         n++;
      end
      if (hcnt == h) begin
         err_count++;
         conclude();
      end
   endtask
   task automatic frame(input logic [7:0] e1, input logic [7:0] e2);
      nxt();
      chk(h1, e1);
      chk(h2, e2);
   endtask
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 4; i++)
         rd(32'(i * 4), 8'h00);
      wr(32'h0000_0010, 8'hFF);
      rd(32'h0000_0010, 8'h00);
      wr(a_lo, 8'hC3);
      rd(a_lo, 8'hC3);
      wr(a_ctl, 8'hC2);
      rd(a_ctl, 8'h02);
      for (int i = 0; i < 7; i++) begin
         cmd(rows[i][0], rows[i][1], rows[i][2]);
         frame(rows[i][3], rows[i][4]);
         if (rows[i][2] == 8'h04)
            chk(stf, 8'h00);
         else
            chk(h3, rows[i][2] == 8'h08 ? h3_in : 8'h00);
         rd(a_ctl, rows[i][2] & 8'hF3);
         frame(rows[i][5], rows[i][6]);
         rd(a_ptr, rows[i][6]);
      end
      cmd(8'h63, 8'h0E, 8'h14);
      frame(8'h63, 8'h0E);
      for (int i = 0; i < 5 && h1 !== 8'h61; i++)
         nxt();
      chk(h2, 8'hA4);
      frame(8'h60, 8'h00);
      cmd(8'h62, 8'h11, 8'h20);
      frame(8'h62, 8'h11);
      cmd(8'h61, 8'h22, 8'h20);
      frame(8'h62, 8'h11);
      conclude();
   end
endmodule  // spa_ptr_adjust_test
